/* File: srl_map.vh */
// Register map, field positions and reset values of the set-reset latch unit.
// Assumes byte addressing on a 32-bit Avalon-MM slave, 8-bit registers.
`ifndef SRL_MAP_VH
`define SRL_MAP_VH

// Byte offsets
`define SRL_OFF_CTRL0        5'h00
`define SRL_OFF_CTRL1        5'h04
`define SRL_OFF_ALT_PIN      5'h08
`define SRL_OFF_SYNC         5'h0C
`define SRL_OFF_PIN_DIR      5'h10
`define SRL_OFF_STATUS       5'h14

// latch_control0 fields
`define SRL_C0_FW_RST        0
`define SRL_C0_FW_SET        1
`define SRL_C0_QBAR_EN       2
`define SRL_C0_Q_EN          3
`define SRL_C0_PER_LO        4
`define SRL_C0_PER_HI        6

// latch_control1 fields
`define SRL_C1_SET_CMP1      0
`define SRL_C1_SET_CMP2      1
`define SRL_C1_SET_EXT       2
`define SRL_C1_SET_CLK       3
`define SRL_C1_RST_CMP1      4
`define SRL_C1_RST_CMP2      5
`define SRL_C1_RST_EXT       6
`define SRL_C1_RST_CLK       7

// alt_pin_function_ctrl, comp_sync_enable and pin_direction fields
`define SRL_ALT_QBAR_SEL     0
`define SRL_SYNC_CMP1        0
`define SRL_SYNC_CMP2        1
`define SRL_DIR_Q            0
`define SRL_DIR_QBAR         1
`define SRL_DIR_QBAR_ALT     2

// Status fields
`define SRL_ST_LATCH         0
`define SRL_ST_SET_ANY       1
`define SRL_ST_RST_ANY       2
`define SRL_ST_CMP1          3
`define SRL_ST_CMP2          4
`define SRL_ST_EXT           5
`define SRL_ST_CLK           6

// Reset values
`define SRL_RST_CTRL0        8'h00
`define SRL_RST_CTRL1        8'h00
`define SRL_RST_ALT_PIN      8'h00
`define SRL_RST_SYNC         8'h00
`define SRL_RST_PIN_DIR      8'h07

// Periodic source: counter width, period is 2^(sel+1) clk_sys cycles
`define SRL_PER_CNT_W        8

`endif

/* File: srl_period_gen.v */
// Periodic pulse source for the latch: one-cycle pulse every 2^(sel+1) clocks.
// Assumes clk_sys free running and a synchronous active-low reset.
`timescale 1ns/1ps
`include "srl_map.vh"

module srl_period_gen (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_b,
  // Control
  input  wire [2:0] period_sel,
  // Output
  output reg        tick_q
);

  reg  [`SRL_PER_CNT_W-1:0] cnt_q;
  wire [`SRL_PER_CNT_W:0]   mask_w;
  wire [`SRL_PER_CNT_W-1:0] mask;

  assign mask_w = (9'h002 << period_sel) - 9'h001;
  assign mask   = mask_w[`SRL_PER_CNT_W-1:0];

  // Free running so a period change takes effect within one long period
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 8'h01;
      tick_q <= ((cnt_q & mask) == mask); // RULE_08
    end
  end

endmodule

/* File: srl_top.v */
// Set-reset latch unit with Avalon-MM register access and three output pins.
// Assumes all inputs synchronous to clk_sys; t1_src_clk is the post-prescale
// timer source clock sampled as a level.
//
// What this block does
// RULE_01: Latch follows set and reset without delay; latch_q here takes them at the next clk_sys edge
// RULE_02: All set and reset sources active high
// RULE_03: Five source kinds: pulse, comp1, comp2, pin, clock
// RULE_04: Set and reset together gives reset
// RULE_05: Firmware pulse bits act once, self clear
// RULE_06: Either comparator may set or reset
// RULE_07: External input pin may set or reset
// RULE_08: Three-bit field selects internal clock period
// RULE_09: Separate clock set and clock reset enables
// RULE_10: Separate enables for true, complement outputs
// RULE_11: Both outputs may drive pins together
// RULE_12: Select bit moves complement output to alternate pin
// RULE_13: Firmware clears pin direction before driving
// RULE_14: No reset initialises the latch state
// RULE_15: Synced comparator captured on timer clock fall
// RULE_16: Complement output always inverse of true; here an undriven pin reads zero, so pins can match while one is off
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "srl_map.vh"

module srl_top (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Latch sources
  input  wire        comp1_out,
  input  wire        comp2_out,
  input  wire        t1_src_clk,
  input  wire        ext_latch_input,
  // True output pin
  output reg         q_pin_out,
  output reg         q_pin_oe,
  // Complement output, default pin
  output reg         qbar_pin_out,
  output reg         qbar_pin_oe,
  // Complement output, alternate pin
  output reg         qbar_alt_pin_out,
  output reg         qbar_alt_pin_oe
);

  // Registers
  reg  [7:0] latch_control0_q;
  reg  [7:0] latch_control1_q;
  reg  [7:0] alt_pin_function_ctrl_q;
  reg  [7:0] comp_sync_enable_q;
  reg  [7:0] pin_direction_q;

  // Firmware pulses, alive for exactly one cycle
  reg        fw_set_pulse_q;
  reg        fw_reset_pulse_q;

  // Comparator synchronisation
  reg        t1_prev_q;
  reg        comp1_cap_q;
  reg        comp2_cap_q;
  wire       t1_fall;
  wire       comp1_sync_out;
  wire       comp2_sync_out;

  // Periodic source
  wire       clk_tick;

  // Latch
  reg        latch_q;
  wire       set_any;
  wire       rst_any;
  wire       latch_d;

  // Bus decode
  wire       bus_req;
  wire       wr_ok;
  wire       hit_ctrl0;
  wire       hit_ctrl1;
  wire       hit_alt;
  wire       hit_sync;
  wire       hit_dir;
  wire       hit_status;
  reg  [7:0] rd_mux;
  wire [7:0] status;

  // Output enables
  wire       q_en;
  wire       qbar_en;
  wire       qbar_alt;
  wire       q_drive;
  wire       qbar_drive;
  wire       qbar_alt_drive;

  // --------------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // --------------------------------------------------------------------
  assign bus_req    = avs_read | avs_write;
  assign wr_ok      = avs_write & ~avs_waitrequest;
  assign hit_ctrl0  = (avs_address == `SRL_OFF_CTRL0);
  assign hit_ctrl1  = (avs_address == `SRL_OFF_CTRL1);
  assign hit_alt    = (avs_address == `SRL_OFF_ALT_PIN);
  assign hit_sync   = (avs_address == `SRL_OFF_SYNC);
  assign hit_dir    = (avs_address == `SRL_OFF_PIN_DIR);
  assign hit_status = (avs_address == `SRL_OFF_STATUS);

  // Waitrequest drops for one cycle after a request is seen, then rises
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Readback; pulse bits are never stored so they read as zero
  always @* begin
    rd_mux = 8'h00;
    if (hit_ctrl0) begin
      rd_mux = latch_control0_q;
    end else if (hit_ctrl1) begin
      rd_mux = latch_control1_q;
    end else if (hit_alt) begin
      rd_mux = alt_pin_function_ctrl_q;
    end else if (hit_sync) begin
      rd_mux = comp_sync_enable_q;
    end else if (hit_dir) begin
      rd_mux = pin_direction_q;
    end else if (hit_status) begin
      rd_mux = status;
    end
  end

  // Read data stands from the cycle waitrequest drops until the next read
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, rd_mux};
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      latch_control0_q        <= `SRL_RST_CTRL0;
      latch_control1_q        <= `SRL_RST_CTRL1;
      alt_pin_function_ctrl_q <= `SRL_RST_ALT_PIN;
      comp_sync_enable_q      <= `SRL_RST_SYNC;
      pin_direction_q         <= `SRL_RST_PIN_DIR;
    end else if (wr_ok) begin
      if (hit_ctrl0) begin
        latch_control0_q <= {avs_writedata[7:2], 2'b00};
      end
      if (hit_ctrl1) begin
        latch_control1_q <= avs_writedata[7:0];
      end
      if (hit_alt) begin
        alt_pin_function_ctrl_q <= {7'h00,
                                    avs_writedata[`SRL_ALT_QBAR_SEL]};
      end
      if (hit_sync) begin
        comp_sync_enable_q <= {6'h00, avs_writedata[1:0]};
      end
      if (hit_dir) begin
        pin_direction_q <= {5'h00, avs_writedata[2:0]};
      end
    end
  end

  // One write gives one pulse; it clears itself the next cycle
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      fw_set_pulse_q   <= 1'b0;
      fw_reset_pulse_q <= 1'b0;
    end else begin
      fw_set_pulse_q   <= wr_ok & hit_ctrl0 &
                          avs_writedata[`SRL_C0_FW_SET]; // RULE_05
      fw_reset_pulse_q <= wr_ok & hit_ctrl0 &
                          avs_writedata[`SRL_C0_FW_RST]; // RULE_05
    end
  end

  // --------------------------------------------------------------------
  // Comparator synchronisation to the falling timer source clock
  // --------------------------------------------------------------------
  assign t1_fall = t1_prev_q & ~t1_src_clk;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      t1_prev_q   <= 1'b0;
      comp1_cap_q <= 1'b0;
      comp2_cap_q <= 1'b0;
    end else begin
      t1_prev_q <= t1_src_clk;
      if (t1_fall) begin
        comp1_cap_q <= comp1_out; // RULE_15
        comp2_cap_q <= comp2_out; // RULE_15
      end
    end
  end

  assign comp1_sync_out = comp_sync_enable_q[`SRL_SYNC_CMP1] ?
                          comp1_cap_q : comp1_out; // RULE_15
  assign comp2_sync_out = comp_sync_enable_q[`SRL_SYNC_CMP2] ?
                          comp2_cap_q : comp2_out; // RULE_15

  // --------------------------------------------------------------------
  // Periodic source
  // --------------------------------------------------------------------
  srl_period_gen u_period (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .period_sel (latch_control0_q[`SRL_C0_PER_HI:`SRL_C0_PER_LO]),
    .tick_q     (clk_tick)
  );

  // --------------------------------------------------------------------
  // Set and reset gathering, all sources active high
  // --------------------------------------------------------------------
  assign set_any =
      fw_set_pulse_q                                                // RULE_03
    | (latch_control1_q[`SRL_C1_SET_CMP1] & comp1_sync_out)         // RULE_06
    | (latch_control1_q[`SRL_C1_SET_CMP2] & comp2_sync_out)         // RULE_06
    | (latch_control1_q[`SRL_C1_SET_EXT]  & ext_latch_input)        // RULE_07
    | (latch_control1_q[`SRL_C1_SET_CLK]  & clk_tick);              // RULE_09

  assign rst_any =
      fw_reset_pulse_q                                              // RULE_02
    | (latch_control1_q[`SRL_C1_RST_CMP1] & comp1_sync_out)         // RULE_06
    | (latch_control1_q[`SRL_C1_RST_CMP2] & comp2_sync_out)         // RULE_06
    | (latch_control1_q[`SRL_C1_RST_EXT]  & ext_latch_input)        // RULE_07
    | (latch_control1_q[`SRL_C1_RST_CLK]  & clk_tick);              // RULE_09

  // Reset wins over set
  assign latch_d = rst_any ? 1'b0 :
                   set_any ? 1'b1 : latch_q; // RULE_04

  // Evaluated every cycle with no enable, so the state tracks its inputs
  // at the next edge; deliberately no reset term, state is unknown at start
  always @(posedge clk_sys) begin
    latch_q <= latch_d; // RULE_01 RULE_14
  end

  // --------------------------------------------------------------------
  // Output pins
  // --------------------------------------------------------------------
  assign q_en     = latch_control0_q[`SRL_C0_Q_EN];
  assign qbar_en  = latch_control0_q[`SRL_C0_QBAR_EN];
  assign qbar_alt = alt_pin_function_ctrl_q[`SRL_ALT_QBAR_SEL];

  // Driver stays off while the pin is configured as an input
  assign q_drive        = q_en &
                          ~pin_direction_q[`SRL_DIR_Q]; // RULE_10 RULE_13
  assign qbar_drive     = qbar_en & ~qbar_alt &
                          ~pin_direction_q[`SRL_DIR_QBAR]; // RULE_12 RULE_13
  assign qbar_alt_drive = qbar_en & qbar_alt &
                          ~pin_direction_q[`SRL_DIR_QBAR_ALT]; // RULE_12

  // Pins take latch_d so they change on the same edge as the latch;
  // undriven pins show zero, which keeps an unknown latch off the bus
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      q_pin_out        <= 1'b0;
      q_pin_oe         <= 1'b0;
      qbar_pin_out     <= 1'b0;
      qbar_pin_oe      <= 1'b0;
      qbar_alt_pin_out <= 1'b0;
      qbar_alt_pin_oe  <= 1'b0;
    end else begin
      q_pin_oe         <= q_drive;        // RULE_11
      qbar_pin_oe      <= qbar_drive;     // RULE_11
      qbar_alt_pin_oe  <= qbar_alt_drive;
      q_pin_out        <= q_drive & latch_d;                // RULE_10
      qbar_pin_out     <= qbar_drive & ~latch_d;            // RULE_16
      qbar_alt_pin_out <= qbar_alt_drive & ~latch_d;        // RULE_16
    end
  end

  // --------------------------------------------------------------------
  // Status view of the block's own state
  // --------------------------------------------------------------------
  assign status = {1'b0,
                   clk_tick,
                   ext_latch_input,
                   comp2_sync_out,
                   comp1_sync_out,
                   rst_any,
                   set_any,
                   latch_q};

endmodule

/* File: srl_top_monitor.sv */
// Checker for srl_top: bus handshake and output pin relations.
// Assumes one clk_sys domain and binding to every srl_top instance.
`timescale 1ns/1ps
module srl_top_monitor (
  // Clock and reset
  input wire        clk_sys,
  input wire        rst_b,
  // Bus
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Pins
  input wire        q_pin_out,
  input wire        q_pin_oe,
  input wire        qbar_pin_out,
  input wire        qbar_pin_oe,
  input wire        qbar_alt_pin_out,
  input wire        qbar_alt_pin_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("no answer after one wait state");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_rd_upper: assert property (!avs_waitrequest |->
    avs_readdata[31:8] == 24'h000000) else $error("read data upper not zero");
  chk_rd_stand: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved without read");
  chk_q_inverse: assert property (q_pin_oe && qbar_pin_oe |->
    qbar_pin_out != q_pin_out) else $error("complement equals true output");
  chk_alt_inverse: assert property (q_pin_oe && qbar_alt_pin_oe |->
    qbar_alt_pin_out != q_pin_out) else $error("alternate equals true output");
  chk_qbar_one_pin: assert property (!(qbar_pin_oe && qbar_alt_pin_oe))
    else $error("complement driven on both pins");
  chk_q_idle_low: assert property (!q_pin_oe |-> !q_pin_out)
    else $error("true pin not low while undriven");
  chk_qbar_idle_low: assert property (!qbar_pin_oe |-> !qbar_pin_out)
    else $error("complement pin not low while undriven");
  cov_both_pins: cover property (q_pin_oe && qbar_pin_oe);
  cov_alt_pin: cover property (q_pin_oe && qbar_alt_pin_oe);
  cov_write: cover property (avs_write && !avs_waitrequest);
endmodule

bind srl_top srl_top_monitor i_mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .q_pin_out(q_pin_out),
  .q_pin_oe(q_pin_oe), .qbar_pin_out(qbar_pin_out),
  .qbar_pin_oe(qbar_pin_oe), .qbar_alt_pin_out(qbar_alt_pin_out),
  .qbar_alt_pin_oe(qbar_alt_pin_oe));

/* File: srl_src_model.sv */
// Far-side source: the timer source clock; the bench drives comparators and input pin.
// Assumes the bench sets levels; the timer clock stands still unless run.
`timescale 1ns/1ps
module srl_src_model (
  // Clock and reset
  input  wire  clk_sys,
  input  wire  rst_b,
  // Commands
  input  wire  t1_run,
  // Source outputs
  output logic t1_src_clk
);
  logic [1:0] div_q;
  // Slow timer clock so capture on its falling edge is clearly separate
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      div_q      <= 2'h0;
      t1_src_clk <= 1'b0;
    end else if (t1_run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h2) begin
        div_q      <= 2'h0;
        t1_src_clk <= !t1_src_clk;
      end
    end
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for srl_top: registers, sources, pins, period.
// Assumes srl_src_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "srl_map.vh"
module tb_top;
  logic clk_sys, rst_b, avs_read, avs_write, c1, c2, ext, t1_run, t1;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, q, q_oe, nq, nq_oe, nqa, nqa_oe, ex;
  logic [31:0] exp_q[$], msk_q[$];
  int err_count, checks_done, n;
  integer seed;
  srl_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .comp1_out(c1), .comp2_out(c2), .t1_src_clk(t1), .ext_latch_input(ext),
    .q_pin_out(q), .q_pin_oe(q_oe), .qbar_pin_out(nq), .qbar_pin_oe(nq_oe),
    .qbar_alt_pin_out(nqa), .qbar_alt_pin_oe(nqa_oe));
  srl_src_model i_src (.clk_sys(clk_sys), .rst_b(rst_b), .t1_run(t1_run),
    .t1_src_clk(t1));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = !clk_sys;
  end
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task bus(input logic rd, input logic [4:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    if (rd) avs_read <= 1'b1;
    else avs_write <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 8'h00);
  endtask
  // Scoreboard side: takes the oldest note whenever a read completes
  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      checks_done++;
      if ((avs_readdata & msk_q[0]) !== exp_q[0]) begin
        $display("unexpected readdata exp %h got %h", exp_q[0], avs_readdata);
        err_count++;
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  task pins(input logic [5:0] e);
    repeat (3) @(posedge clk_sys);
    checks_done++;
    if ({q, q_oe, nq, nq_oe, nqa, nqa_oe} !== e) begin
      $display("unexpected pins exp %b got %b", e, {q, q_oe, nq, nq_oe, nqa,
        nqa_oe});
      err_count++;
    end
  endtask
  task wait_fall(output int c);
    logic p;
    // Count edges from one fall to the next, so a period of P reads as P
    c = 1;
    p = q;
    @(posedge clk_sys);
    while (!(p === 1'b1 && q === 1'b0) && c < 600) begin
      p = q;
      @(posedge clk_sys);
      c++;
    end
    if (c >= 600) begin
      err_count++;
      tally_and_finish;
    end
  endtask
  initial begin
    {avs_read, avs_write, c1, c2, ext, t1_run} = 6'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    err_count = 0;
    checks_done = 0;
    seed = 32'hFD9FD9A8;
    rst_b = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(`SRL_OFF_CTRL0, 32'hFF, 32'h00);
    rd(`SRL_OFF_CTRL1, 32'hFF, 32'h00);
    rd(`SRL_OFF_ALT_PIN, 32'hFF, 32'h00);
    rd(`SRL_OFF_SYNC, 32'hFF, 32'h00);
    rd(`SRL_OFF_PIN_DIR, 32'hFF, 32'h07);
    rd(5'h18, 32'hFFFFFFFF, 32'h00);
    wr(`SRL_OFF_CTRL0, 8'h02);
    rd(`SRL_OFF_STATUS, 32'h01, 32'h01);
    rd(`SRL_OFF_CTRL0, 32'hFF, 32'h00);
    wr(`SRL_OFF_CTRL0, 8'h03);
    rd(`SRL_OFF_STATUS, 32'h01, 32'h00);
    wr(`SRL_OFF_CTRL1, 8'h04);
    ext <= 1'b1;
    rd(`SRL_OFF_STATUS, 32'h01, 32'h01);
    ext <= 1'b0;
    wr(`SRL_OFF_CTRL1, 8'h40);
    ext <= 1'b1;
    rd(`SRL_OFF_STATUS, 32'h01, 32'h00);
    wr(`SRL_OFF_CTRL0, 8'h02);
    rd(`SRL_OFF_STATUS, 32'h01, 32'h00);
    ext <= 1'b0;
    wr(`SRL_OFF_CTRL1, 8'h21);
    ex = 1'b0;
    for (int i = 0; i < 8; i++) begin
      c1 <= 1'($random(seed));
      c2 <= 1'($random(seed));
      @(posedge clk_sys);
      ex = c2 ? 1'b0 : (c1 ? 1'b1 : ex);
      rd(`SRL_OFF_STATUS, 32'h01, {31'h0, ex});
    end
    {c1, c2} <= 2'b00;
    wr(`SRL_OFF_SYNC, 8'h01);
    t1_run <= 1'b1;
    // Stop two edges after the last fall, so c1 rising is not captured until t1_run is set again
    repeat (14) @(posedge clk_sys);
    t1_run <= 1'b0;
    c1 <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(`SRL_OFF_STATUS, 32'h08, 32'h00);
    t1_run <= 1'b1;
    repeat (14) @(posedge clk_sys);
    rd(`SRL_OFF_STATUS, 32'h08, 32'h08);
    c1 <= 1'b0;
    wr(`SRL_OFF_CTRL1, 8'h08);
    wr(`SRL_OFF_CTRL0, 8'h01);
    repeat (4) @(posedge clk_sys);
    rd(`SRL_OFF_STATUS, 32'h01, 32'h01);
    wr(`SRL_OFF_CTRL1, 8'h00);
    wr(`SRL_OFF_CTRL0, 8'h02);
    wr(`SRL_OFF_PIN_DIR, 8'h00);
    pins(6'b000000);
    wr(`SRL_OFF_CTRL0, 8'h0C);
    pins(6'b110100);
    wr(`SRL_OFF_ALT_PIN, 8'h01);
    pins(6'b110001);
    wr(`SRL_OFF_PIN_DIR, 8'h07);
    pins(6'b000000);
    wr(`SRL_OFF_PIN_DIR, 8'h00);
    wr(`SRL_OFF_CTRL1, 8'h84);
    ext <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(`SRL_OFF_CTRL0, {1'b0, s[2:0], 4'h8});
      // Let falls still timed by the old period select drain from the pin
      repeat (3) @(posedge clk_sys);
      wait_fall(n);
      wait_fall(n);
      checks_done++;
      if (n != (2 << s)) begin
        $display("unexpected period exp %0d got %0d", 2 << s, n);
        err_count++;
      end
    end
    tally_and_finish;
  end
endmodule
